// >>> design/rfts_pkg.sv
// Package: command codes, reset values, time constants and carriers for the TX trigger / sleep block
`default_nettype none
package rfts_pkg;
    // Configuration command codes (also the register offsets)
    localparam logic [7:0] OFS_SLEEP_MODE   = 8'h01;
    localparam logic [7:0] OFS_SLEEP_TIME   = 8'h02;
    localparam logic [7:0] OFS_INIT_DELAY   = 8'h03;
    localparam logic [7:0] OFS_INIT_LENGTH  = 8'h0c;
    localparam logic [7:0] OFS_FORCE_INIT   = 8'h0d;
    localparam logic [7:0] OFS_IN2_FUNCTION = 8'h16;
    localparam logic [7:0] OFS_PIN_WAKE     = 8'h1d;
    localparam logic [7:0] OFS_TX_THRESHOLD = 8'h20;
    localparam logic [7:0] OFS_SILENT_TIME  = 8'h21;
    localparam logic [7:0] OFS_IN2_TIMER    = 8'h31;

    // Values after reset
    localparam logic [7:0]  RST_SLEEP_MODE   = 8'h00;
    localparam logic [15:0] RST_SLEEP_TIME   = 16'h0064;
    localparam logic [15:0] RST_INIT_DELAY   = 16'hffff;
    localparam logic [7:0]  RST_INIT_LENGTH  = 8'h01;
    localparam logic [7:0]  RST_IN2_FUNCTION = 8'h00;
    localparam logic [7:0]  RST_PIN_WAKE     = 8'h00;
    localparam logic [15:0] RST_TX_THRESHOLD = 16'h0001;
    localparam logic [15:0] RST_SILENT_TIME  = 16'h0020;
    localparam logic [15:0] RST_IN2_TIMER    = 16'h0000;

    // Field limits
    localparam logic [15:0] INIT_DELAY_NEVER = 16'hffff;
    localparam logic [15:0] SLEEP_TIME_MIN   = 16'h0010;
    localparam logic [7:0]  SLEEP_MODE_MAX   = 8'h08;
    localparam logic [7:0]  IN2_FUNC_MAX     = 8'h02;
    localparam logic [7:0]  PIN_WAKE_MAX     = 8'h01;

    // Time base: clock period, units and derived cycle counts
    localparam int CLK_PERIOD_NS   = 100;
    localparam int FAST_UNIT_US    = 200;
    localparam int SLOW_UNIT_MS    = 100;
    localparam int FAST_TICK_CYC   = (FAST_UNIT_US * 1000) / CLK_PERIOD_NS;
    localparam int FAST_PER_SLOW   = (SLOW_UNIT_MS * 1000) / FAST_UNIT_US;
    localparam int CYCLIC_BASE_MS  = 500;
    localparam int CYCLIC_BASE_SLW = CYCLIC_BASE_MS / SLOW_UNIT_MS;

    // Sleep modes
    typedef enum logic [7:0] {
        RFTS_SM_NONE   = 8'h00,
        RFTS_SM_PIN    = 8'h01,
        RFTS_SM_SERIAL = 8'h02,
        RFTS_SM_CYC_A  = 8'h03,
        RFTS_SM_CYC_B  = 8'h04,
        RFTS_SM_CYC_C  = 8'h05,
        RFTS_SM_CYC_D  = 8'h06,
        RFTS_SM_CYC_E  = 8'h07,
        RFTS_SM_CYC_F  = 8'h08
    } rfts_sleep_mode_t;

    // Second input functions
    typedef enum logic [7:0] {
        RFTS_IN2_OFF  = 8'h00,
        RFTS_IN2_CMD  = 8'h01,
        RFTS_IN2_RTS  = 8'h02
    } rfts_in2_func_t;

    // Host configuration command and its answer
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  code;
        logic [15:0] data;
    } rfts_cmd_t;

    typedef struct packed {
        logic        valid;
        logic        err;
        logic [15:0] data;
    } rfts_rsp_t;
endpackage
`default_nettype wire

// >>> design/rfts_ctrl.sv
// RF transmit trigger, second input selection and sleep / wake-up initializer control
//
// Behaviour
// - Transmit after programmed serial silence; zero disables
// - Either silence or byte threshold starts transmission
// - Transmit once byte threshold reached in buffer
// - Second input: off, command, or RTS
// - Force command prepends initializer to next transmission
// - Initializer sent once inactivity reaches programmed delay
// - Delay all-ones disables automatic initializer
// - Initializer lasts programmed length in 100 ms
// - Wake pin leaves cyclic sleep when enabled
// - Sleep mode decode: none, pin, serial, cyclic
// - Sleep after programmed inactivity in 100 ms
// - Inactivity sleep only in cyclic, serial modes
// - Serial or RF traffic restarts inactivity timers
`default_nettype none
module rfts_ctrl (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire rfts_pkg::rfts_cmd_t cmd,
    input  wire logic             ser_byte,
    input  wire logic             rf_activity,
    input  wire logic             second_digital_input,
    input  wire logic             sleep_pin,
    input  wire logic             wake_pin,
    output logic                  tx_start,
    output logic                  tx_with_init,
    output logic                  init_busy,
    output logic                  sleep_active,
    output logic                  cyclic_poll,
    output logic                  in2_cmd_mode,
    output logic                  in2_rts_hold,
    output rfts_pkg::rfts_rsp_t   rsp
);
    import rfts_pkg::*;

    // Register readback decode
    function automatic logic [16:0] reg_read(input logic [7:0] code, input logic [7:0] sm, input logic [15:0] st,
                                             input logic [15:0] ht, input logic [7:0] lh, input logic [7:0] rt,
                                             input logic [7:0] pw, input logic [15:0] rb, input logic [15:0] ro,
                                             input logic [15:0] t2);
        logic [16:0] r;
        r = {1'b0, 16'h0000};
        unique case (code)
            OFS_SLEEP_MODE:   r = {1'b0, 8'h00, sm};
            OFS_SLEEP_TIME:   r = {1'b0, st};
            OFS_INIT_DELAY:   r = {1'b0, ht};
            OFS_INIT_LENGTH:  r = {1'b0, 8'h00, lh};
            OFS_IN2_FUNCTION: r = {1'b0, 8'h00, rt};
            OFS_PIN_WAKE:     r = {1'b0, 8'h00, pw};
            OFS_TX_THRESHOLD: r = {1'b0, rb};
            OFS_SILENT_TIME:  r = {1'b0, ro};
            OFS_IN2_TIMER:    r = {1'b0, t2};
            default:          r = {1'b1, 16'h0000};
        endcase
        return r;
    endfunction

    // Cyclic sleep modes 3..8
    function automatic logic is_cyclic(input logic [7:0] sm);
        return (sm >= RFTS_SM_CYC_A) && (sm <= RFTS_SM_CYC_F);
    endfunction

    // Time base state
    logic [11:0] pre_q, pre_d;
    logic [8:0]  sub_q, sub_d;
    logic        tick_fast, tick_slow;

    // Configuration state
    logic [7:0]  sm_q, sm_d, lh_q, lh_d, rt_q, rt_d, pw_q, pw_d;
    logic [15:0] st_q, st_d, ht_q, ht_d, rb_q, rb_d, ro_q, ro_d, t2_q, t2_d;
    logic        force_q, force_d;
    rfts_rsp_t   rsp_q, rsp_d;

    // Trigger and sleep state
    logic [15:0] cnt_q, cnt_d, silent_q, silent_d, inact_q, inact_d;
    logic [7:0]  left_q, left_d, cyc_q, cyc_d;
    logic        txs_q, txs_d, txi_q, txi_d, busy_q, busy_d;
    logic        slp_q, slp_d, poll_q, poll_d, cmdm_q, cmdm_d, rtsh_q, rtsh_d;

    logic        activity, silent_hit, count_hit, auto_due, force_cmd, cyc_mode;
    logic [16:0] rd;
    logic [7:0]  period;

    // Prescaler is 12 + 9 bits; a time base that does not fit raises an error at elaboration
    if (FAST_TICK_CYC < 2 || FAST_TICK_CYC > 4096 || FAST_PER_SLOW < 2 || FAST_PER_SLOW > 512) begin : g_tick_chk
        $error("time base constants do not fit the prescaler");
    end

    // One prescaler feeds both units so every duration is a whole unit count
    always_comb begin
        tick_fast = (pre_q == 12'(FAST_TICK_CYC - 1));
        tick_slow = tick_fast && (sub_q == 9'(FAST_PER_SLOW - 1));
        pre_d = tick_fast ? 12'h000 : pre_q + 12'h001;
        sub_d = sub_q;
        if (tick_fast) begin
            sub_d = tick_slow ? 9'h000 : sub_q + 9'h001;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pre_q <= 12'h000;
            sub_q <= 9'h000;
        end else if (ce) begin
            pre_q <= pre_d;
            sub_q <= sub_d;
        end
    end

    // Command decode; out-of-range writes are refused so the decode stays legal
    always_comb begin
        sm_d = sm_q;
        st_d = st_q;
        ht_d = ht_q;
        lh_d = lh_q;
        rt_d = rt_q;
        pw_d = pw_q;
        rb_d = rb_q;
        ro_d = ro_q;
        t2_d = t2_q;
        force_cmd = cmd.valid && (cmd.code == OFS_FORCE_INIT);
        rd = reg_read(cmd.code, sm_q, st_q, ht_q, lh_q, rt_q, pw_q, rb_q, ro_q, t2_q);
        rsp_d = '0;
        if (cmd.valid) begin
            rsp_d.valid = 1'b1;
            rsp_d.data  = force_cmd ? 16'h0000 : rd[15:0];
            rsp_d.err   = force_cmd ? 1'b0 : rd[16];
            if (cmd.write && !force_cmd && !rd[16]) begin
                unique case (cmd.code)
                    OFS_SLEEP_MODE:   if (cmd.data <= 16'(SLEEP_MODE_MAX)) sm_d = cmd.data[7:0]; else rsp_d.err = 1'b1;
                    OFS_SLEEP_TIME:   if (cmd.data >= SLEEP_TIME_MIN) st_d = cmd.data; else rsp_d.err = 1'b1;
                    OFS_INIT_DELAY:   ht_d = cmd.data;
                    OFS_INIT_LENGTH:  if (cmd.data[15:8] == 8'h00) lh_d = cmd.data[7:0]; else rsp_d.err = 1'b1;
                    OFS_IN2_FUNCTION: if (cmd.data <= 16'(IN2_FUNC_MAX)) rt_d = cmd.data[7:0]; else rsp_d.err = 1'b1;
                    OFS_PIN_WAKE:     if (cmd.data <= 16'(PIN_WAKE_MAX)) pw_d = cmd.data[7:0]; else rsp_d.err = 1'b1;
                    OFS_TX_THRESHOLD: if (cmd.data != 16'h0000) rb_d = cmd.data; else rsp_d.err = 1'b1;
                    OFS_SILENT_TIME:  ro_d = cmd.data;
                    OFS_IN2_TIMER:    t2_d = cmd.data;
                    default:          rsp_d.err = 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sm_q  <= RST_SLEEP_MODE;
            st_q  <= RST_SLEEP_TIME;
            ht_q  <= RST_INIT_DELAY;
            lh_q  <= RST_INIT_LENGTH;
            rt_q  <= RST_IN2_FUNCTION;
            pw_q  <= RST_PIN_WAKE;
            rb_q  <= RST_TX_THRESHOLD;
            ro_q  <= RST_SILENT_TIME;
            t2_q  <= RST_IN2_TIMER;
            rsp_q <= '0;
        end else if (ce) begin
            sm_q  <= sm_d;
            st_q  <= st_d;
            ht_q  <= ht_d;
            lh_q  <= lh_d;
            rt_q  <= rt_d;
            pw_q  <= pw_d;
            rb_q  <= rb_d;
            ro_q  <= ro_d;
            t2_q  <= t2_d;
            rsp_q <= rsp_d;
        end
    end

    // Transmit trigger: byte count, serial silence, initializer request
    always_comb begin
        activity   = ser_byte || rf_activity || txs_q;
        silent_hit = (ro_q != 16'h0000) && (cnt_q != 16'h0000) && (silent_q >= ro_q);
        count_hit  = (cnt_q >= rb_q);
        auto_due   = (ht_q != INIT_DELAY_NEVER) && (inact_q >= ht_q);
        txs_d      = silent_hit || count_hit;
        txi_d      = txs_d && (force_q || auto_due);
        // A byte landing with the start begins the next packet's count
        if (txs_d) begin
            cnt_d = ser_byte ? 16'h0001 : 16'h0000;
        end else begin
            cnt_d = (ser_byte && cnt_q != 16'hffff) ? cnt_q + 16'h0001 : cnt_q;
        end
        // Silence counts only while data waits; any byte restarts it
        if (ser_byte || txs_d || cnt_q == 16'h0000) begin
            silent_d = 16'h0000;
        end else begin
            silent_d = (tick_fast && silent_q != 16'hffff) ? silent_q + 16'h0001 : silent_q;
        end
        // Force request survives a start in the same cycle: the set wins
        force_d = force_cmd ? 1'b1 : (txs_d ? 1'b0 : force_q);
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt_q    <= 16'h0000;
            silent_q <= 16'h0000;
            txs_q    <= 1'b0;
            txi_q    <= 1'b0;
            force_q  <= 1'b0;
        end else if (ce) begin
            cnt_q    <= cnt_d;
            silent_q <= silent_d;
            txs_q    <= txs_d;
            txi_q    <= txi_d;
            force_q  <= force_d;
        end
    end

    // Inactivity, initializer length, sleep and cyclic wake
    always_comb begin
        cyc_mode = is_cyclic(sm_q);
        period   = 8'(CYCLIC_BASE_SLW) << (sm_q[3:0] - 4'h3);
        if (activity) begin
            inact_d = 16'h0000;
        end else begin
            inact_d = (tick_slow && inact_q != 16'hffff) ? inact_q + 16'h0001 : inact_q;
        end
        // Initializer runs lh whole units from the start that carries it
        if (txs_q && txi_q) begin
            left_d = lh_q;
        end else begin
            left_d = (tick_slow && left_q != 8'h00) ? left_q - 8'h01 : left_q;
        end
        busy_d = (left_d != 8'h00);
        slp_d  = slp_q;
        unique case (sm_q)
            RFTS_SM_NONE: slp_d = 1'b0;
            RFTS_SM_PIN:  slp_d = sleep_pin;
            default: begin
                if (activity || (cyc_mode && pw_q[0] && wake_pin)) begin
                    slp_d = 1'b0;
                end else if (inact_q >= st_q) begin
                    slp_d = 1'b1;
                end
            end
        endcase
        // Periodic listen pulse while asleep in a cyclic mode
        poll_d = 1'b0;
        cyc_d  = 8'h00;
        if (slp_q && cyc_mode && tick_slow) begin
            poll_d = (cyc_q == period - 8'h01);
            cyc_d  = poll_d ? 8'h00 : cyc_q + 8'h01;
        end else if (slp_q && cyc_mode) begin
            cyc_d = cyc_q;
        end
        cmdm_d = (rt_q == RFTS_IN2_CMD) && second_digital_input;
        rtsh_d = (rt_q == RFTS_IN2_RTS) && second_digital_input;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            inact_q <= 16'h0000;
            left_q  <= 8'h00;
            busy_q  <= 1'b0;
            slp_q   <= 1'b0;
            poll_q  <= 1'b0;
            cyc_q   <= 8'h00;
            cmdm_q  <= 1'b0;
            rtsh_q  <= 1'b0;
        end else if (ce) begin
            inact_q <= inact_d;
            left_q  <= left_d;
            busy_q  <= busy_d;
            slp_q   <= slp_d;
            poll_q  <= poll_d;
            cyc_q   <= cyc_d;
            cmdm_q  <= cmdm_d;
            rtsh_q  <= rtsh_d;
        end
    end

    // Outputs straight from flip-flops
    assign tx_start     = txs_q;
    assign tx_with_init = txi_q;
    assign init_busy    = busy_q;
    assign sleep_active = slp_q;
    assign cyclic_poll  = poll_q;
    assign in2_cmd_mode = cmdm_q;
    assign in2_rts_hold = rtsh_q;
    assign rsp          = rsp_q;

    // Checks
    a_silent_start: assert property (@(posedge clock) disable iff (rst)
        ce && silent_hit |=> tx_start) else $error("silence did not start transmission");
    a_no_early_tx: assert property (@(posedge clock) disable iff (rst)
        ce && ro_q == 16'h0000 && cnt_q < rb_q |=> !tx_start) else $error("early transmission");
    a_either_start: assert property (@(posedge clock) disable iff (rst)
        ce && tx_start |-> $past(silent_hit) || $past(count_hit)) else $error("start without cause");
    a_force_init: assert property (@(posedge clock) disable iff (rst)
        ce && force_q && txs_d |=> tx_with_init) else $error("forced initializer dropped");
    a_never_auto: assert property (@(posedge clock) disable iff (rst)
        ce && ht_q == INIT_DELAY_NEVER && !force_q |=> !tx_with_init) else $error("automatic initializer");
    a_auto_init: assert property (@(posedge clock) disable iff (rst)
        ce && txs_d && auto_due |=> tx_with_init) else $error("due initializer missing");
    a_init_length: assert property (@(posedge clock) disable iff (rst)
        ce && tx_start && tx_with_init && lh_q != 8'h00 |=> init_busy) else $error("initializer not running");
    a_in2_decode: assert property (@(posedge clock) disable iff (rst)
        ce |=> !(in2_cmd_mode && in2_rts_hold)) else $error("second input decode clash");
    a_pin_wake: assert property (@(posedge clock) disable iff (rst)
        ce && cyc_mode && pw_q[0] && wake_pin |=> !sleep_active)
        else $error("pin wake ignored");
    a_no_sleep_mode: assert property (@(posedge clock) disable iff (rst)
        ce && sm_q == 8'h00 |=> !sleep_active) else $error("sleep in no-sleep mode");
    a_traffic_restart: assert property (@(posedge clock) disable iff (rst)
        ce && activity |=> inact_q == 16'h0000) else $error("inactivity not restarted");
    a_tick_period: assert property (@(posedge clock) disable iff (rst)
        ce && tick_fast |=> !tick_fast) else $error("tick too frequent");
    a_count_start: assert property (@(posedge clock) disable iff (rst)
        ce && count_hit |=> tx_start) else $error("threshold did not start transmission");
    a_zero_length: assert property (@(posedge clock) disable iff (rst)
        ce && tx_start && tx_with_init && lh_q == 8'h00 |=> !init_busy) else $error("empty initializer ran");
    a_force_keep: assert property (@(posedge clock) disable iff (rst)
        ce && force_q && !txs_d |=> force_q) else $error("force request lost");
    a_in2_follow: assert property (@(posedge clock) disable iff (rst)
        ce |=> in2_rts_hold == ($past(rt_q) == RFTS_IN2_RTS && $past(second_digital_input)))
        else $error("flow control input not followed");

    // Sleep entry, wake and refused mode writes
    a_pin_sleep: assert property (@(posedge clock) disable iff (rst)
        ce && sm_q == RFTS_SM_PIN |=> sleep_active == $past(sleep_pin)) else $error("pin sleep not followed");
    a_sleep_entry: assert property (@(posedge clock) disable iff (rst)
        ce && sm_q >= RFTS_SM_SERIAL && !activity && !wake_pin && inact_q >= st_q |=> sleep_active)
        else $error("inactivity did not start sleep");
    a_traffic_wake: assert property (@(posedge clock) disable iff (rst)
        ce && sm_q >= RFTS_SM_SERIAL && activity |=> !sleep_active) else $error("traffic did not wake");
    a_refuse_mode: assert property (@(posedge clock) disable iff (rst)
        ce && cmd.valid && cmd.write && cmd.code == OFS_SLEEP_MODE && cmd.data > 16'(SLEEP_MODE_MAX)
        |=> rsp.err && $stable(sm_q)) else $error("illegal sleep mode taken");
    c_pin_wake: cover property (@(posedge clock) disable iff (rst) sleep_active && cyc_mode ##1 !sleep_active);
    c_silent_tx: cover property (@(posedge clock) disable iff (rst) silent_hit && !count_hit ##1 tx_start);
    c_count_tx: cover property (@(posedge clock) disable iff (rst) count_hit ##1 tx_start);
    c_init_tx: cover property (@(posedge clock) disable iff (rst) tx_start && tx_with_init);
    c_cyc_poll: cover property (@(posedge clock) disable iff (rst) cyclic_poll);
endmodule
`default_nettype wire

// >>> bench/rfts_host_model.sv
// Host serial port and remote radio stand-in: byte strobes and RF traffic
`default_nettype none
module rfts_host_model (
    input  wire logic clock,
    output var  logic ser_byte,
    output var  logic rf_activity
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle at time zero so the block never sees an unknown strobe
    initial begin
        ser_byte    = 1'b0;
        rf_activity = 1'b0;
    end

    // Bytes back to back (gap 0) or spaced; with gap 0 the strobe stays high one cycle per byte for all n bytes
    task automatic send_bytes(input int n, input int gap);
        for (int i = 0; i < n; i++) begin
            @(posedge clock);
            ser_byte <= 1'b1;
            if (gap > 0) begin
                @(posedge clock);
                ser_byte <= 1'b0;
                repeat (gap - 1) @(posedge clock);
            end
        end
        if (gap == 0) begin
            @(posedge clock);
            ser_byte <= 1'b0;
        end
    endtask

    // One cycle of radio traffic from a remote
    task automatic pulse_rf();
        @(posedge clock);
        rf_activity <= 1'b1;
        @(posedge clock);
        rf_activity <= 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> bench/rf_tx_trigger_sleep_ctrl_tb_top.sv
// Testbench for the transmit trigger, second input and sleep control block
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
    $display("[ERR] %s exp=%0h got=%0h", nm, (e), (g)); end end
module rf_tx_trigger_sleep_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import rfts_pkg::*;

    logic      clock, rst, ce, second_digital_input, sleep_pin, wake_pin, ser_byte, rf_activity;
    logic      tx_start, tx_with_init, init_busy, sleep_active, cyclic_poll, in2_cmd_mode, in2_rts_hold;
    rfts_cmd_t cmd;
    rfts_rsp_t rsp;
    int        errors, total_checks, n;
    int        cycles = 0;
    logic [7:0]  codes [9] = '{OFS_SLEEP_MODE, OFS_SLEEP_TIME, OFS_INIT_DELAY, OFS_INIT_LENGTH,
                               OFS_IN2_FUNCTION, OFS_PIN_WAKE, OFS_TX_THRESHOLD, OFS_SILENT_TIME, OFS_IN2_TIMER};
    logic [15:0] dflt [9]  = '{16'h0000, 16'h0064, 16'hffff, 16'h0001, 16'h0000, 16'h0000, 16'h0001,
                               16'h0020, 16'h0000};
    logic [15:0] wval [9]  = '{16'h0008, 16'h0010, 16'h1234, 16'h00ff, 16'h0002, 16'h0001, 16'h0005,
                               16'habcd, 16'h4321};

    rfts_ctrl dut_u (.clock(clock), .rst(rst), .ce(ce), .cmd(cmd), .ser_byte(ser_byte),
        .rf_activity(rf_activity), .second_digital_input(second_digital_input), .sleep_pin(sleep_pin),
        .wake_pin(wake_pin), .tx_start(tx_start), .tx_with_init(tx_with_init), .init_busy(init_busy),
        .sleep_active(sleep_active), .cyclic_poll(cyclic_poll), .in2_cmd_mode(in2_cmd_mode),
        .in2_rts_hold(in2_rts_hold), .rsp(rsp));
    rfts_host_model host_u (.clock(clock), .ser_byte(ser_byte), .rf_activity(rf_activity));

    // 10 MHz clock
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // Hang guard; the whole run needs about 7k cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            errors++;
            end_of_test();
        end
    end

    // Verdict and end of run
    task automatic end_of_test();
        if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Reset held for 8 cycles, then released off the sampling edge
    task automatic do_reset();
        @(posedge clock);
        rst <= 1'b1;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        #1;
    endtask

    // One command; the answer stands in the cycle after the taking edge
    task automatic access(input logic w, input logic [7:0] code, input logic [15:0] d, output rfts_rsp_t r);
        @(posedge clock);
        cmd <= {1'b1, w, code, d};
        @(posedge clock);
        cmd <= '0;
        #1 r = rsp;
    endtask

    task automatic rd_chk(input logic [7:0] code, input logic [15:0] exp);
        rfts_rsp_t r;
        access(1'b0, code, 16'h0000, r);
        `CHK("read_valid", 1'b1, r.valid)
        `CHK("read_err", 1'b0, r.err)
        `CHK("read_data", exp, r.data)
    endtask

    task automatic wr_chk(input logic [7:0] code, input logic [15:0] d, input logic exp_err);
        rfts_rsp_t r;
        access(1'b1, code, d, r);
        `CHK("write_valid", 1'b1, r.valid)
        `CHK("write_err", exp_err, r.err)
    endtask

    task automatic chk_defaults();
        for (int i = 0; i < 9; i++) rd_chk(codes[i], dflt[i]);
    endtask

    // Polls each cycle once outputs settle; n is cycles until the start pulse
    task automatic wait_start(input int lim, output int k);
        k = 0;
        do begin
            @(posedge clock);
            #1;
            k++;
        end while (tx_start !== 1'b1 && k < lim);
    endtask

    // Main sequence
    initial begin
        rst = 1'b1; ce = 1'b1; cmd = '0; second_digital_input = 1'b0;
        sleep_pin = 1'b0; wake_pin = 1'b0; errors = 0; total_checks = 0;
        do_reset();
        chk_defaults();
        for (int i = 0; i < 9; i++) begin
            wr_chk(codes[i], wval[i], 1'b0);
            rd_chk(codes[i], wval[i]);
        end
        // Out-of-range writes are refused and the old value stays
        wr_chk(OFS_SLEEP_MODE, 16'h0009, 1'b1);
        rd_chk(OFS_SLEEP_MODE, 16'h0008);
        wr_chk(OFS_SLEEP_TIME, 16'h000f, 1'b1);
        rd_chk(OFS_SLEEP_TIME, 16'h0010);
        wr_chk(OFS_IN2_FUNCTION, 16'h0003, 1'b1);
        rd_chk(OFS_IN2_FUNCTION, 16'h0002);
        wr_chk(OFS_PIN_WAKE, 16'h0002, 1'b1);
        wr_chk(OFS_INIT_LENGTH, 16'h0100, 1'b1);
        rd_chk(OFS_INIT_LENGTH, 16'h00ff);
        wr_chk(OFS_TX_THRESHOLD, 16'h0000, 1'b1);
        rd_chk(OFS_TX_THRESHOLD, 16'h0005);
        wr_chk(8'h7f, 16'h0000, 1'b1);
        do_reset();
        chk_defaults();
        // Byte threshold alone, silence trigger off
        wr_chk(OFS_SILENT_TIME, 16'h0000, 1'b0);
        wr_chk(OFS_TX_THRESHOLD, 16'h0003, 1'b0);
        host_u.send_bytes(2, 0);
        wait_start(5000, n);
        `CHK("start_below_threshold", 1'b0, tx_start)
        host_u.send_bytes(1, 1);
        wait_start(20, n);
        `CHK("threshold_latency", 1, n)
        // Silence of one fast tick starts a lone byte
        wr_chk(OFS_SILENT_TIME, 16'h0001, 1'b0);
        wr_chk(OFS_TX_THRESHOLD, 16'h0010, 1'b0);
        host_u.send_bytes(1, 1);
        wait_start(4100, n);
        `CHK("silence_start", 1'b1, tx_start)
        `CHK("silence_bound", 1'b1, n <= FAST_TICK_CYC + 1)
        // Both armed: threshold wins the race
        wr_chk(OFS_TX_THRESHOLD, 16'h0002, 1'b0);
        host_u.send_bytes(2, 0);
        wait_start(20, n);
        `CHK("first_trigger", 1, n)
        // Initializer: automatic, disabled, forced
        wr_chk(OFS_TX_THRESHOLD, 16'h0001, 1'b0);
        wr_chk(OFS_INIT_LENGTH, 16'h0000, 1'b0);
        wr_chk(OFS_INIT_DELAY, 16'h0000, 1'b0);
        host_u.pulse_rf();
        host_u.send_bytes(1, 1);
        wait_start(20, n);
        `CHK("auto_init", 1'b1, tx_with_init)
        @(posedge clock);
        #1;
        `CHK("zero_length_busy", 1'b0, init_busy)
        wr_chk(OFS_INIT_DELAY, 16'hffff, 1'b0);
        host_u.send_bytes(1, 1);
        wait_start(20, n);
        `CHK("never_init", 1'b0, tx_with_init)
        wr_chk(OFS_FORCE_INIT, 16'h0000, 1'b0);
        host_u.send_bytes(1, 1);
        wait_start(20, n);
        `CHK("forced_init", 1'b1, tx_with_init)
        host_u.send_bytes(1, 1);
        wait_start(20, n);
        `CHK("force_consumed", 1'b0, tx_with_init)
        wr_chk(OFS_INIT_LENGTH, 16'h0006, 1'b0);
        wr_chk(OFS_FORCE_INIT, 16'h0000, 1'b0);
        host_u.send_bytes(1, 1);
        wait_start(20, n);
        @(posedge clock);
        #1;
        `CHK("init_busy_rise", 1'b1, init_busy)
        do_reset();
        `CHK("busy_after_reset", 1'b0, init_busy)
        // Second input decode for every function and level
        for (int f = 0; f < 3; f++) begin
            for (int l = 0; l < 2; l++) begin
                wr_chk(OFS_IN2_FUNCTION, 16'(f), 1'b0);
                @(posedge clock);
                second_digital_input <= l[0];
                repeat (2) @(posedge clock);
                #1;
                `CHK("in2_cmd", (f == 1 && l == 1), in2_cmd_mode)
                `CHK("in2_rts", (f == 2 && l == 1), in2_rts_hold)
            end
        end
        // Sleep pin ignored outside pin sleep; pin sleep follows it
        for (int m = 0; m < 3; m += 2) begin
            wr_chk(OFS_SLEEP_MODE, 16'(m), 1'b0);
            @(posedge clock);
            sleep_pin <= 1'b1;
            wake_pin <= 1'b1;
            repeat (3) @(posedge clock);
            #1;
            `CHK("no_pin_sleep", 1'b0, sleep_active)
            @(posedge clock);
            sleep_pin <= 1'b0;
            wake_pin <= 1'b0;
        end
        wr_chk(OFS_SLEEP_MODE, 16'h0001, 1'b0);
        @(posedge clock);
        sleep_pin <= 1'b1;
        @(posedge clock);
        #1;
        `CHK("pin_sleep", 1'b1, sleep_active)
        @(posedge clock);
        sleep_pin <= 1'b0;
        @(posedge clock);
        #1;
        `CHK("pin_wake", 1'b0, sleep_active)
        // Asleep by pin, then cyclic: wake pin counts only once enabled
        @(posedge clock);
        sleep_pin <= 1'b1;
        wake_pin <= 1'b1;
        wr_chk(OFS_SLEEP_MODE, 16'h0003, 1'b0);
        repeat (2) @(posedge clock);
        #1;
        `CHK("wake_pin_off", 1'b1, sleep_active)
        `CHK("poll_idle", 1'b0, cyclic_poll)
        wr_chk(OFS_PIN_WAKE, 16'h0001, 1'b0);
        @(posedge clock);
        #1;
        `CHK("wake_pin_on", 1'b0, sleep_active)
        end_of_test();
    end
endmodule
`default_nettype wire
